// ==== rtl/i2c_port_consts.vh ====
`ifndef I2C_PORT_CONSTS_VH
`define I2C_PORT_CONSTS_VH

// ----------------------------------------
// slave addresses (7-bit, without r/w bit)
// ----------------------------------------
`define ADDR_DEFAULT      7'h21
`define ADDR_ALTERNATE    7'h20

// ----------------------------------------
// subaddress map
// ----------------------------------------
`define SUB_VERSION       8'h00
`define SUB_DEC_LO        8'h01
`define SUB_DEC_HI        8'h19
`define SUB_STAT1         8'h1E
`define SUB_STAT2         8'h1F
`define SUB_AIC_LO        8'h23
`define SUB_AIC_HI        8'h25
`define SUB_CMP_LO        8'h29
`define SUB_CMP_HI        8'h2F
`define SUB_ACG_LO        8'h30
`define SUB_ACG_HI        8'h3A
`define SUB_SLC_LO        8'h40
`define SUB_SLC_HI        8'h5E
`define SUB_SST_LO        8'h60
`define SUB_SST_HI        8'h62
`define SUB_GLB_LO        8'h80
`define SUB_TSKB_HI       8'hEF

// ----------------------------------------
// reset and filler values
// ----------------------------------------
`define REG_RESET         8'h00
`define RSVD_READ         8'hFF
`define VERSION_DEFAULT   8'h10

`endif

// ==== rtl/i2c_reg_file.v ====
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_consts.vh"

module i2c_reg_file (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_i,
    // access
    input  wire       wr_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    output wire [7:0] rdata_o,
    // status inputs
    input  wire [7:0] version_i,
    input  wire [7:0] dec_status1_i,
    input  wire [7:0] dec_status2_i,
    input  wire [23:0] slicer_status_i
);

    reg  [7:0] mem [0:255];
    reg  [7:0] rd;

    // ----------------------------------------
    // writable decode
    // ----------------------------------------
    function is_rw;
        input [7:0] a;
        begin
            is_rw = (a >= `SUB_DEC_LO && a <= `SUB_DEC_HI) ||
                    (a >= `SUB_AIC_LO && a <= `SUB_AIC_HI) ||
                    (a >= `SUB_CMP_LO && a <= `SUB_ACG_HI) ||
                    (a >= `SUB_SLC_LO && a <= `SUB_SLC_HI) ||
                    (a >= `SUB_GLB_LO && a <= `SUB_TSKB_HI);
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 256; g = g + 1) begin : g_reg
            if (g >= `SUB_DEC_LO && g <= `SUB_TSKB_HI) begin : g_store
                always @(posedge clk_sys_i) begin
                    if (rst_i) begin
                        mem[g] <= `REG_RESET;
                    end else if (wr_i && addr_i == g[7:0] && is_rw(g[7:0])) begin
                        mem[g] <= wdata_i;
                    end
                end
            end else begin : g_none
                always @* begin
                    mem[g] = `REG_RESET;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always @* begin
        rd = `RSVD_READ;
        if (addr_i == `SUB_VERSION) begin
            rd = version_i;
        end else if (addr_i == `SUB_STAT1) begin
            rd = dec_status1_i;
        end else if (addr_i == `SUB_STAT2) begin
            rd = dec_status2_i;
        end else if (addr_i >= `SUB_SST_LO && addr_i <= `SUB_SST_HI) begin
            rd = slicer_status_i[(addr_i[1:0])*8 +: 8];
        end else if (is_rw(addr_i)) begin
            rd = mem[addr_i];
        end
    end

    assign rdata_o = rd;

endmodule // i2c_reg_file
`default_nettype wire

// ==== rtl/i2c_register_access_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_consts.vh"

module i2c_register_access_port (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // two-wire bus
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    // strap and status
    input  wire        addr_alt_i,
    input  wire [7:0]  dec_status1_i,
    input  wire [7:0]  dec_status2_i,
    input  wire [23:0] slicer_status_i,
    // observation
    output reg  [7:0]  subaddr_o,
    output reg         busy_o
);

    parameter [7:0] VERSION_CODE = `VERSION_DEFAULT; // arbitrary value

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_ACK  = 6'h04;
    localparam [5:0] ST_WRX  = 6'h08;
    localparam [5:0] ST_TX   = 6'h10;
    localparam [5:0] ST_MACK = 6'h20;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_d;
    reg       sda_d;
    reg       alt_s1;
    reg       alt_s2;
    reg       alt_lat;
    reg [5:0] state;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            alt_s1   <= 1'b0;
            alt_s2   <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
            alt_s1   <= addr_alt_i;
            alt_s2   <= alt_s1;
        end
    end

    // strap followed on every cycle in idle, held while a transfer is in progress
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            alt_lat <= 1'b0;
        end else if (state == ST_IDLE) begin
            alt_lat <= alt_s2;
        end
    end

    wire scl_rise = scl_sync[1] & ~scl_d;
    wire scl_fall = ~scl_sync[1] & scl_d;
    wire start_c  = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    wire stop_c   = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] shift;
    reg  [3:0] bitcnt;
    reg        is_read;
    reg        have_sub;
    reg        ack_drv;
    reg        wr_pulse;
    reg  [7:0] wdata;
    reg  [7:0] tx;
    wire [7:0] rdata;
    wire [6:0] my_addr = alt_lat ? `ADDR_ALTERNATE : `ADDR_DEFAULT;

    i2c_reg_file u_regs (
        .clk_sys_i       (clk_sys_i),
        .rst_i           (rst_i),
        .wr_i            (wr_pulse),
        .addr_i          (subaddr_o),
        .wdata_i         (wdata),
        .rdata_o         (rdata),
        .version_i       (VERSION_CODE),
        .dec_status1_i   (dec_status1_i),
        .dec_status2_i   (dec_status2_i),
        .slicer_status_i (slicer_status_i)
    );

    // ----------------------------------------
    // protocol engine
    // ----------------------------------------
    // oversampled at 100 MHz, far above 400 kbit/s
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            shift     <= 8'h00;
            bitcnt    <= 4'h0;
            is_read   <= 1'b0;
            have_sub  <= 1'b0;
            ack_drv   <= 1'b0;
            wr_pulse  <= 1'b0;
            wdata     <= 8'h00;
            tx        <= 8'h00;
            subaddr_o <= 8'h00;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            wr_pulse <= 1'b0;
            sda_o    <= 1'b0;
            if (stop_c) begin
                state    <= ST_IDLE;
                sda_oe_o <= 1'b0;
                busy_o   <= 1'b0;
            end else if (start_c) begin
                state    <= ST_ADDR;
                bitcnt   <= 4'h0;
                sda_oe_o <= 1'b0;
                busy_o   <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_ADDR, ST_WRX: begin
                        if (scl_rise) begin
                            shift  <= {shift[6:0], sda_sync[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == my_addr) begin
                                    is_read  <= shift[0];
                                    have_sub <= 1'b0;
                                    ack_drv  <= 1'b1;
                                    sda_oe_o <= 1'b1;
                                    tx       <= rdata;
                                    state    <= ST_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                if (!have_sub) begin
                                    subaddr_o <= shift;
                                    have_sub  <= 1'b1;
                                end else begin
                                    wdata    <= shift;
                                    wr_pulse <= 1'b1;
                                end
                                sda_oe_o <= 1'b1;
                                state    <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (wr_pulse == 1'b0 && have_sub && !is_read && !ack_drv) begin
                                subaddr_o <= subaddr_o;
                            end
                            ack_drv <= 1'b0;
                            if (is_read) begin
                                tx       <= {rdata[6:0], 1'b0};
                                sda_oe_o <= ~rdata[7];
                                state    <= ST_TX;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state    <= ST_WRX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h7) begin
                                sda_oe_o <= 1'b0;
                                bitcnt   <= 4'h0;
                                state    <= ST_MACK;
                            end else begin
                                sda_oe_o <= ~tx[7];
                                tx       <= {tx[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            subaddr_o <= subaddr_o + 8'h01;
                            if (sda_sync[1]) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_ACK;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
                // step after each written data byte
                if (wr_pulse) begin
                    subaddr_o <= subaddr_o + 8'h01;
                end
            end
        end
    end

endmodule // i2c_register_access_port
`default_nettype wire

// ==== sim/i2c_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_port_props (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    // bus and observation
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [7:0] subaddr_o,
    input wire logic       busy_o
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_start; scl_i && $fell(sda_i); endsequence
    sequence s_stop; scl_i && $rose(sda_i); endsequence
    sequence s_hold; sda_oe_o [*8]; endsequence
    property p_reset_quiet; $fell(rst_i) |-> !sda_oe_o && !busy_o && subaddr_o == 8'h00; endproperty
    property p_open_drain; sda_o == 1'b0; endproperty
    property p_idle_quiet; !busy_o |-> !sda_oe_o; endproperty
    property p_oe_scl_low; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2); endproperty
    property p_ack_hold; $rose(sda_oe_o) |-> s_hold; endproperty
    property p_busy_on; s_start |-> ##[1:6] busy_o; endproperty
    property p_busy_off; s_stop |-> ##[1:6] !busy_o; endproperty
    property p_sub_busy; $changed(subaddr_o) |-> busy_o; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset state wrong");
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved with scl high");
    a_ack_hold: assert property (p_ack_hold) else $error("drive too short");
    a_busy_on: assert property (p_busy_on) else $error("start missed");
    a_busy_off: assert property (p_busy_off) else $error("stop missed");
    a_sub_busy: assert property (p_sub_busy) else $error("pointer moved while idle");
endmodule // i2c_port_props
`default_nettype wire

// ==== sim/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter int H = 126
) (
    // clock and line
    input  wire logic       clk_sys_i,
    input  wire logic       sda_i,
    // drives
    output var  logic       scl_o,
    output var  logic       sda_low_o,
    // byte results
    output var  logic       res_v_o,
    output var  logic [8:0] res_d_o
);
    // ----
    // bus master
    // ----
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_v_o = 1'b0;
        res_d_o = 9'h000;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // bit period 2.52 us, just under 400 kbit/s
    task automatic clk_bit(input logic b, output logic r);
        wt(H / 4);
        sda_low_o = ~b;
        wt(H - H / 4);
        scl_o = 1'b1;
        wt(H / 2);
        r = sda_i;
        wt(H / 2);
        scl_o = 1'b0;
    endtask
    task automatic start_c;
        wt(H / 4);
        sda_low_o = 1'b0;
        wt(H / 2);
        scl_o = 1'b1;
        wt(H);
        sda_low_o = 1'b1;
        wt(H);
        scl_o = 1'b0;
    endtask
    task automatic stop_c;
        wt(H / 4);
        sda_low_o = 1'b1;
        wt(H / 2);
        scl_o = 1'b1;
        wt(H);
        sda_low_o = 1'b0;
        wt(H);
    endtask
    task automatic xfer(input logic [7:0] d, input logic mack, input logic rd);
        logic [7:0] got;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(rd | d[i], r);
            got[i] = r;
        end
        clk_bit(rd ? ~mack : 1'b1, r);
        res_d_o = {~rd & ~r, got};
        res_v_o = 1'b1;
        wt(1);
        res_v_o = 1'b0;
    endtask
endmodule // i2c_host_model
`default_nettype wire

// ==== sim/i2c_register_access_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_consts.vh"
module i2c_register_access_port_bench;
    // ----
    // wiring
    // ----
    localparam logic [7:0] VER = 8'h5C; // arbitrary value
    logic [7:0]  bases [4] = '{8'h00, 8'h1E, 8'h5E, 8'hEF};
    logic [7:0]  lens [4] = '{8'h02, 8'h02, 8'h06, 8'h01};
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        addr_alt_i = 1'b0;
    logic [7:0]  st1, st2, dev, wd [256];
    logic [23:0] sst;
    logic        scl, m_low, sda_o, sda_oe_o, busy_o, res_v;
    logic [7:0]  subaddr_o;
    logic [8:0]  res_d, expq [$];
    wire logic   sda = (sda_oe_o ? sda_o : 1'b1) & ~m_low;
    int          failures = 0;
    int          cmp_count = 0;
    int          seed = 65164;
    always #5 clk_sys_i = ~clk_sys_i;
    i2c_host_model #(.H(126)) m (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low),
        .res_v_o(res_v), .res_d_o(res_d));
    i2c_register_access_port #(.VERSION_CODE(VER)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_alt_i(addr_alt_i), .dec_status1_i(st1),
        .dec_status2_i(st2), .slicer_status_i(sst), .subaddr_o(subaddr_o), .busy_o(busy_o));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] expv(input logic [7:0] a);
        if (a == `SUB_VERSION) return VER;
        if (a == `SUB_STAT1) return st1;
        if (a == `SUB_STAT2) return st2;
        if (a >= 8'h60 && a <= 8'h62) return sst[8*(a-8'h60) +: 8];
        if ((a >= 8'h01 && a <= 8'h19) || (a >= 8'h23 && a <= 8'h25) || (a >= 8'h29 && a <= 8'h3A)
            || (a >= 8'h40 && a <= 8'h5E) || (a >= 8'h80 && a <= 8'hEF)) return wd[a];
        return 8'hFF;
    endfunction
    task automatic wr_burst(input logic [7:0] base, input logic [7:0] n);
        expq.push_back({1'b1, dev});
        expq.push_back({1'b1, base});
        m.start_c();
        m.xfer(dev, 1'b0, 1'b0);
        m.xfer(base, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            wd[8'(base + i)] = 8'($random(seed));
            expq.push_back({1'b1, wd[8'(base + i)]});
            m.xfer(wd[8'(base + i)], 1'b0, 1'b0);
        end
        m.stop_c();
    endtask
    task automatic rd_burst(input logic [7:0] base, input logic [7:0] n);
        expq.push_back({1'b1, dev});
        expq.push_back({1'b1, base});
        expq.push_back({1'b1, dev | 8'h01});
        m.start_c();
        m.xfer(dev, 1'b0, 1'b0);
        m.xfer(base, 1'b0, 1'b0);
        m.start_c();
        m.xfer(dev | 8'h01, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            expq.push_back({1'b0, expv(8'(base + i))});
            m.xfer(8'hFF, i < n - 1, 1'b1);
        end
        m.stop_c();
    endtask
    always @(posedge clk_sys_i) begin
        if (res_v) begin
            if (expq.size() == 0) chk(res_d, 9'h1FF);
            else chk(res_d, expq.pop_front());
        end
    end
    initial begin
        repeat (110000) @(posedge clk_sys_i);
        failures++;
        wrap_up();
    end
    initial begin
        st1 = 8'($random(seed));
        st2 = 8'($random(seed));
        sst = 24'($random(seed));
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        for (int k = 0; k < 4; k++) begin
            addr_alt_i = (k == 3);
            dev = (k == 3) ? 8'h40 : 8'h42;
            wr_burst(bases[k], lens[k]);
            chk({1'b0, subaddr_o}, {1'b0, 8'(bases[k] + lens[k])});
            rd_burst(bases[k], lens[k]);
        end
        expq.push_back({1'b0, 8'h42});
        m.start_c();
        m.xfer(8'h42, 1'b0, 1'b0);
        m.stop_c();
        repeat (4) @(negedge clk_sys_i);
        chk(9'(expq.size()), 9'h000);
        wrap_up();
    end
endmodule // i2c_register_access_port_bench
bind i2c_register_access_port i2c_port_props chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .subaddr_o(subaddr_o), .busy_o(busy_o));
`default_nettype wire
